// file: rtl/rsm_pkg.sv
// Package for the reset and supply monitor controller: map, fields, states, timing
package rsm_pkg;
   localparam int          ADDR_W         = 8;
   localparam logic [7:0]  OFS_MON_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_RST_CAUSE  = 8'h04;
   localparam logic [7:0]  OFS_PMU_MODE   = 8'h08;
   // Supply monitor control fields
   localparam int          BIT_MON_EN     = 7;
   localparam int          BIT_RST_STAT   = 6;
   localparam int          BIT_WARN_OK    = 5;
   localparam int          BIT_WARN_IE    = 3;
   localparam logic        WARN_IE_RST    = 1'b1;
   // Reset cause fields
   localparam int          BIT_PIN_FLAG   = 0;
   localparam int          BIT_POR_FLAG   = 1;
   localparam int          BIT_SW_RST     = 4;
   localparam int          BIT_FERR_FLAG  = 6;
   // Power unit mode fields
   localparam int          BIT_POR_POR_MONITOR_DISABLE = 5;
   // Values presented on leaving or during reset
   localparam logic [7:0]  PORT_RST_VAL   = 8'hFF;
   localparam logic [15:0] RESET_VECTOR   = 16'h0000;
   localparam logic [3:0]  WDT_DIVIDE     = 4'hC;
   // Power-on release delay
   localparam int          CLK_MHZ        = 100;
   localparam int          POR_DELAY_US   = 7000;
   localparam int          POR_DELAY_CYC  = POR_DELAY_US * CLK_MHZ;
   localparam int          CNT_W          = 20;

   typedef enum logic [3:0] {
      RSM_ST_POR   = 4'h1,
      RSM_ST_PFAIL = 4'h2,
      RSM_ST_WARM  = 4'h4,
      RSM_ST_RUN   = 4'h8
   } rsm_state_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } rsm_apb_req_t;

   typedef struct packed {
      logic        above_por;
      logic        above_rst;
      logic        above_warn;
   } rsm_supply_t;

   typedef struct packed {
      logic [7:0]  port_latch;
      logic        port_open_drain;
      logic        weak_pullup_en;
   } rsm_port_t;
endpackage

// file: rtl/rsm_ctrl.sv
// Reset and supply monitor controller with APB register access
`timescale 1ns/1ps
module rsm_ctrl #(
   parameter int POR_DELAY = rsm_pkg::POR_DELAY_CYC
) (
   // Clock, reset, enable
   input  wire logic                  CLOCK,
   input  wire logic                  NRST,
   input  wire logic                  CE,
   // APB slave
   input  wire rsm_pkg::rsm_apb_req_t APB_REQ,
   output logic [31:0]                PRDATA,
   output logic                       PREADY,
   output logic                       PSLVERR,
   // Analog comparators and reset pin
   input  wire rsm_pkg::rsm_supply_t  SUPPLY,
   input  wire logic                  RST_PIN_IN,
   output logic                       RST_PIN_OUT,
   output logic                       RST_PIN_OE,
   // Power management and flash
   input  wire logic                  SLEEP,
   input  wire logic                  FLASH_WR_REQ,
   // Core side
   output logic                       CORE_HALT,
   output logic                       IRQ_TIMER_DISABLE,
   output logic                       SP_RESET,
   output logic                       RAM_VALID,
   output rsm_pkg::rsm_port_t         PORT_CTRL,
   output logic                       PC_CLEAR,
   output logic [15:0]                FETCH_ADDR,
   output logic                       CLK_SEL_INTERNAL,
   output logic                       WDT_ENABLE,
   output logic [3:0]                 WDT_DIV,
   output logic                       MON_ACTIVE,
   output logic                       POR_MON_ACTIVE,
   output logic                       EARLY_WARN_IRQ
);
   import rsm_pkg::*;

   typedef struct packed {
      rsm_state_t       st;
      logic [CNT_W-1:0] cnt;
      logic             mon_en;
      logic             mon_sel;
      logic             mon_dis;
      logic             warn_ie;
      logic             por_flag;
      logic             pin_flag;
      logic             ferr_flag;
      logic             ok_r;
      logic             stat_r;
      logic             ram_valid;
      logic             exit_p;
      logic             wdt_en;
      logic [31:0]      prdata;
   } rsm_regs_t;

   rsm_regs_t r_r;
   rsm_regs_t r_nxt;

   localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(POR_DELAY - 1);

   // Monitor may only trip while enabled, selected and not sleeping
   function automatic logic mon_trips(input logic en, input logic sel,
                                      input logic slp, input logic above);
      mon_trips = en && sel && !slp && !above;
   endfunction

   function automatic logic [31:0] read_word(input rsm_regs_t s, input logic [7:0] a);
      read_word = 32'h0000_0000;
      case (a)
         OFS_MON_CTRL: begin
            read_word[BIT_MON_EN]   = s.mon_en;
            read_word[BIT_RST_STAT] = s.stat_r;
            read_word[BIT_WARN_OK]  = s.ok_r;
            read_word[BIT_WARN_IE]  = s.warn_ie;
         end
         OFS_RST_CAUSE: begin
            read_word[BIT_PIN_FLAG]  = s.pin_flag;
            read_word[BIT_POR_FLAG]  = s.por_flag;
            read_word[BIT_FERR_FLAG] = s.ferr_flag;
         end
         OFS_PMU_MODE: begin
            read_word[BIT_POR_POR_MONITOR_DISABLE] = s.mon_dis;
         end
         default: begin
            read_word = 32'h0000_0000;
         end
      endcase
   endfunction

   logic mapped;
   logic wr_acc;
   logic rd_setup;
   logic pin_req;
   logic sw_req;
   logic ferr_req;
   logic warm_req;

   always_comb begin
      mapped   = (APB_REQ.paddr == OFS_MON_CTRL) || (APB_REQ.paddr == OFS_RST_CAUSE)
                 || (APB_REQ.paddr == OFS_PMU_MODE);
      wr_acc   = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && mapped;
      rd_setup = APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite;
      // Own drive of the pin must not look like an external reset
      pin_req  = !RST_PIN_IN && !RST_PIN_OE;
      sw_req   = wr_acc && (APB_REQ.paddr == OFS_RST_CAUSE) && APB_REQ.pwdata[BIT_SW_RST];
      ferr_req = FLASH_WR_REQ && !r_r.mon_en;
      warm_req = pin_req || sw_req || ferr_req;
   end

   always_comb begin
      r_nxt        = r_r;
      r_nxt.exit_p = 1'b0;
      r_nxt.ok_r   = SUPPLY.above_warn;
      r_nxt.stat_r = SUPPLY.above_rst;
      if (rd_setup) begin
         r_nxt.prdata = read_word(r_r, APB_REQ.paddr);
      end
      case (r_r.st)
         RSM_ST_POR: begin
            // Delay restarts whenever the supply dips under the threshold
            if (!SUPPLY.above_por) begin
               r_nxt.cnt = '0;
            end else if (r_r.cnt == DELAY_LAST) begin
               r_nxt.st       = RSM_ST_RUN;
               r_nxt.cnt      = '0;
               r_nxt.exit_p   = 1'b1;
               r_nxt.por_flag = 1'b1;
               r_nxt.mon_en   = 1'b1;
               r_nxt.mon_sel  = 1'b1;
               r_nxt.mon_dis  = 1'b0;
            end else begin
               r_nxt.cnt = r_r.cnt + CNT_W'(1);
            end
         end
         RSM_ST_PFAIL: begin
            if (!SUPPLY.above_por) begin
               r_nxt.st  = RSM_ST_POR;
               r_nxt.cnt = '0;
            end else if (SUPPLY.above_rst) begin
               r_nxt.st       = RSM_ST_RUN;
               r_nxt.exit_p   = 1'b1;
               r_nxt.por_flag = 1'b1;
               r_nxt.mon_en   = 1'b1;
               r_nxt.mon_sel  = 1'b1;
            end
         end
         RSM_ST_WARM: begin
            // Monitor enable and selection untouched here
            if (!SUPPLY.above_por) begin
               r_nxt.st  = RSM_ST_POR;
               r_nxt.cnt = '0;
            end else if (RST_PIN_IN) begin
               r_nxt.st       = RSM_ST_RUN;
               r_nxt.exit_p   = 1'b1;
               r_nxt.por_flag = 1'b0;
            end
         end
         RSM_ST_RUN: begin
            if (!SUPPLY.above_por) begin
               r_nxt.st        = RSM_ST_POR;
               r_nxt.cnt       = '0;
               r_nxt.ram_valid = 1'b0;
            end else if (mon_trips(r_r.mon_en, r_r.mon_sel, SLEEP, SUPPLY.above_rst)) begin
               r_nxt.st        = RSM_ST_PFAIL;
               r_nxt.ram_valid = 1'b0;
            end else if (warm_req && r_r.mon_dis) begin
               r_nxt.st        = RSM_ST_POR;
               r_nxt.cnt       = '0;
               r_nxt.ram_valid = 1'b0;
            end else if (warm_req) begin
               r_nxt.st        = RSM_ST_WARM;
               r_nxt.pin_flag  = pin_req;
               r_nxt.ferr_flag = ferr_req && !pin_req;
            end
         end
         default: begin
            r_nxt.st  = RSM_ST_POR;
            r_nxt.cnt = '0;
         end
      endcase
      // Register writes only land while software is running
      if (wr_acc && r_r.st == RSM_ST_RUN && r_nxt.st == RSM_ST_RUN) begin
         case (APB_REQ.paddr)
            OFS_MON_CTRL: begin
               r_nxt.mon_en  = APB_REQ.pwdata[BIT_MON_EN];
               r_nxt.warn_ie = APB_REQ.pwdata[BIT_WARN_IE];
            end
            OFS_RST_CAUSE: begin
               // Selection follows the power-on flag bit
               r_nxt.mon_sel = APB_REQ.pwdata[BIT_POR_FLAG];
            end
            OFS_PMU_MODE: begin
               r_nxt.mon_dis = APB_REQ.pwdata[BIT_POR_POR_MONITOR_DISABLE];
            end
            default: begin
               r_nxt.mon_dis = r_r.mon_dis;
            end
         endcase
      end
      // warn_ie and wdt_en reset values reload in every reset; mon_en and mon_sel keep theirs in a warm reset
      if (r_r.st != RSM_ST_RUN) begin
         r_nxt.warn_ie = WARN_IE_RST;
         r_nxt.wdt_en  = 1'b0;
      end
      if (r_nxt.exit_p) begin
         r_nxt.wdt_en = 1'b1;
      end
      if (r_r.st == RSM_ST_RUN && r_r.exit_p) begin
         r_nxt.ram_valid = 1'b1;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         r_r           <= '0;
         r_r.st        <= RSM_ST_POR;
         r_r.mon_en    <= 1'b1;
         r_r.mon_sel   <= 1'b1;
         r_r.warn_ie   <= WARN_IE_RST;
      end else if (CE) begin
         r_r <= r_nxt;
      end
   end

   // Zero-wait slave: read data captured in setup, answered in access
   assign PREADY  = 1'b1;
   assign PSLVERR = APB_REQ.psel && APB_REQ.penable && !mapped;
   assign PRDATA  = r_r.prdata;

   always_comb begin
      CORE_HALT         = (r_r.st != RSM_ST_RUN);
      IRQ_TIMER_DISABLE = CORE_HALT;
      SP_RESET          = CORE_HALT;
      RAM_VALID         = r_r.ram_valid;
      // Pin driven low only for power-on and power-fail
      RST_PIN_OUT       = 1'b0;
      RST_PIN_OE        = (r_r.st == RSM_ST_POR) || (r_r.st == RSM_ST_PFAIL);
      PORT_CTRL.port_latch      = PORT_RST_VAL;
      PORT_CTRL.port_open_drain = CORE_HALT;
      PORT_CTRL.weak_pullup_en  = 1'b1;
      PC_CLEAR          = r_r.exit_p;
      FETCH_ADDR        = RESET_VECTOR;
      CLK_SEL_INTERNAL  = CORE_HALT || r_r.exit_p;
      WDT_ENABLE        = r_r.wdt_en;
      WDT_DIV           = WDT_DIVIDE;
      // Sleep gates the monitor, stored bits restore on wake
      MON_ACTIVE        = r_r.mon_en && !SLEEP;
      POR_MON_ACTIVE    = !r_r.mon_dis;
      EARLY_WARN_IRQ    = r_r.warn_ie && !r_r.ok_r;
   end

   property p_pin_drive;
      @(posedge CLOCK) disable iff (!NRST || !CE)
      (r_r.st == RSM_ST_POR || r_r.st == RSM_ST_PFAIL) |-> RST_PIN_OE && !RST_PIN_OUT;
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("reset pin not driven");

   property p_por_hold;
      @(posedge CLOCK) disable iff (!NRST || !CE)
      (r_r.st == RSM_ST_POR && !SUPPLY.above_por) |=> r_r.st == RSM_ST_POR && r_r.cnt == '0;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("left power-on early");

   property p_hard_exit;
      @(posedge CLOCK) disable iff (!NRST || !CE)
      (r_r.st == RSM_ST_RUN && $past(r_r.st) != RSM_ST_RUN && $past(r_r.st) != RSM_ST_WARM)
      |-> r_r.por_flag && r_r.mon_en && r_r.mon_sel;
   endproperty
   a_hard_exit: assert property (p_hard_exit) else $error("hard exit state wrong");

   property p_warm_exit;
      @(posedge CLOCK) disable iff (!NRST || !CE)
      (r_r.st == RSM_ST_WARM && RST_PIN_IN && SUPPLY.above_por)
      |=> r_r.st == RSM_ST_RUN && !r_r.por_flag && r_r.mon_en == $past(r_r.mon_en);
   endproperty
   a_warm_exit: assert property (p_warm_exit) else $error("warm exit wrong");

   property p_pfail_enter;
      @(posedge CLOCK) disable iff (!NRST || !CE)
      (r_r.st == RSM_ST_RUN && SUPPLY.above_por && r_r.mon_en && r_r.mon_sel && !SLEEP
       && !SUPPLY.above_rst) |=> r_r.st == RSM_ST_PFAIL ##1 !RAM_VALID;
   endproperty
   a_pfail_enter: assert property (p_pfail_enter) else $error("no power-fail reset");

   property p_sleep_guard;
      @(posedge CLOCK) disable iff (!NRST || !CE)
      (r_r.st == RSM_ST_RUN && SLEEP) |=> r_r.st != RSM_ST_PFAIL;
   endproperty
   a_sleep_guard: assert property (p_sleep_guard) else $error("fail reset in sleep");

   property p_pfail_fast;
      @(posedge CLOCK) disable iff (!NRST || !CE)
      (r_r.st == RSM_ST_PFAIL && SUPPLY.above_rst && SUPPLY.above_por)
      |=> r_r.st == RSM_ST_RUN ##1 r_r.wdt_en;
   endproperty
   a_pfail_fast: assert property (p_pfail_fast) else $error("power-fail delayed");

   property p_por_monitor_disable_por;
      @(posedge CLOCK) disable iff (!NRST || !CE)
      (r_r.st == RSM_ST_RUN && r_r.mon_dis && pin_req && SUPPLY.above_por
       && !mon_trips(r_r.mon_en, r_r.mon_sel, SLEEP, SUPPLY.above_rst))
      |=> r_r.st == RSM_ST_POR;
   endproperty
   a_por_monitor_disable_por: assert property (p_por_monitor_disable_por) else $error("no full power-on");

   property p_flash_err;
      @(posedge CLOCK) disable iff (!NRST || !CE)
      (r_r.st == RSM_ST_RUN && FLASH_WR_REQ && !r_r.mon_en) |=> CORE_HALT;
   endproperty
   a_flash_err: assert property (p_flash_err) else $error("flash error ignored");

   property p_warn_irq;
      @(posedge CLOCK) disable iff (!NRST || !CE)
      (!SUPPLY.above_warn && r_r.warn_ie && r_r.st == RSM_ST_RUN && !wr_acc)
      |=> EARLY_WARN_IRQ;
   endproperty
   a_warn_irq: assert property (p_warn_irq) else $error("warning irq missing");

   property p_port_state;
      @(posedge CLOCK) disable iff (!NRST || !CE)
      CORE_HALT |-> PORT_CTRL.port_latch == PORT_RST_VAL && PORT_CTRL.port_open_drain
                    && PORT_CTRL.weak_pullup_en;
   endproperty
   a_port_state: assert property (p_port_state) else $error("port not in reset state");
endmodule

// file: testbench/rsm_analog_model.sv
// Behavioural model of the supply comparators and the reset pin
`timescale 1ns/1ps
module rsm_analog_model (
   // Clock and commanded supply levels
   input  wire logic          clk,
   input  wire logic          por_ok,
   input  wire logic          rst_ok,
   input  wire logic          warn_ok,
   input  wire logic          slow,
   // External reset request and the block's pin drive
   input  wire logic          ext_rst,
   input  wire logic          pin_out,
   input  wire logic          pin_oe,
   // Comparator outputs and resolved pin
   output rsm_pkg::rsm_supply_t supply,
   output logic               pin_level
);
   import rsm_pkg::*;
   rsm_supply_t now_s;
   rsm_supply_t lag_r;
   assign now_s = '{above_por: por_ok, above_rst: rst_ok, above_warn: warn_ok};
   always_ff @(posedge clk) begin
      lag_r <= now_s;
   end
   // Slow comparator answers a clock late
   assign supply = slow ? lag_r : now_s;
   // Pull-up wins when nobody pulls the pin down
   assign pin_level = pin_oe ? pin_out : !ext_rst;
endmodule

// file: testbench/test_rsm_ctrl.sv
// Self-checking bench for the reset and supply monitor controller
`timescale 1ns/1ps
module test_rsm_ctrl;
   import rsm_pkg::*;
   localparam int PD = 16;
   logic         clock, nrst, pready, pslverr, pin_lvl, pin_out, pin_oe;
   logic         por_ok, rst_ok, warn_ok, ext_rst, slow, sleep, flash_req;
   logic         halt, tmr_dis, sp_rst, ram_ok, pc_clr, clk_int, wdt_en;
   logic         mon_act, pmon_act, wirq;
   logic [3:0]   wdt_div;
   logic [15:0]  fetch;
   logic [31:0]  prdata, d;
   rsm_apb_req_t apb_req;
   rsm_supply_t  supply;
   rsm_port_t    port;
   int           num_errors = 0;
   int           tests_run = 0;
   int           n;

   always #5 clock = ~clock;

   rsm_analog_model u_rsm_analog_model (.clk(clock), .por_ok(por_ok), .rst_ok(rst_ok),
      .warn_ok(warn_ok), .slow(slow), .ext_rst(ext_rst), .pin_out(pin_out),
      .pin_oe(pin_oe), .supply(supply), .pin_level(pin_lvl));

   rsm_ctrl #(.POR_DELAY(PD)) u_rsm_ctrl (.CLOCK(clock), .NRST(nrst), .CE(1'b1),
      .APB_REQ(apb_req), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SUPPLY(supply), .RST_PIN_IN(pin_lvl), .RST_PIN_OUT(pin_out), .RST_PIN_OE(pin_oe),
      .SLEEP(sleep), .FLASH_WR_REQ(flash_req), .CORE_HALT(halt),
      .IRQ_TIMER_DISABLE(tmr_dis), .SP_RESET(sp_rst), .RAM_VALID(ram_ok),
      .PORT_CTRL(port), .PC_CLEAR(pc_clr), .FETCH_ADDR(fetch), .CLK_SEL_INTERNAL(clk_int),
      .WDT_ENABLE(wdt_en), .WDT_DIV(wdt_div), .MON_ACTIVE(mon_act),
      .POR_MON_ACTIVE(pmon_act), .EARLY_WARN_IRQ(wirq));

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   // Request held until pready is seen at a rising edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic err);
      int k;
      k = 0;
      @(posedge clock);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge clock);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 20);
      d = prdata;
      chk("pslverr", pslverr, err);
      apb_req <= '0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v, 1'b0);
   endtask

   task rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0, 1'b0);
   endtask

   task wait_halt(input logic lvl, input int maxc);
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (halt !== lvl && n < maxc);
   endtask

   task t_por();
      @(negedge clock);
      chk("halt", halt, 1'b1);
      chk("tmr_dis", tmr_dis, 1'b1);
      chk("sp_rst", sp_rst, 1'b1);
      chk("pin_oe", pin_oe, 1'b1);
      chk("pin_out", pin_out, 1'b0);
      chk("port", port, {8'hFF, 2'b11});
      wait_halt(1'b0, 40);
      chk("por_delay", n >= PD - 1 && n <= PD + 3, 1'b1);
      chk("pc_clr", pc_clr, 1'b1);
      chk("clk_int", clk_int, 1'b1);
      chk("fetch", fetch, 16'h0000);
      chk("wdt_en", wdt_en, 1'b1);
      chk("wdt_div", wdt_div, 4'hC);
      chk("pullup", port, {8'hFF, 2'b01});
      rd(OFS_MON_CTRL);
      chk("mon_ctrl", d, 32'hE8);
      rd(OFS_RST_CAUSE);
      chk("por_flag", d[BIT_POR_FLAG], 1'b1);
      apb(1'b0, 8'h0C, 32'h0, 1'b1);
      chk("unmapped", d, 32'h0);
      $display("t_por done");
   endtask

   task t_sw();
      chk("ram_ok", ram_ok, 1'b1);
      wr(OFS_RST_CAUSE, 32'h0);
      wr(OFS_MON_CTRL, 32'h08);
      wr(OFS_RST_CAUSE, 32'h10);
      wait_halt(1'b1, 4);
      chk("sw_halt", halt, 1'b1);
      chk("sw_pin", pin_oe, 1'b0);
      wait_halt(1'b0, 8);
      chk("sw_ram", ram_ok, 1'b1);
      rd(OFS_RST_CAUSE);
      chk("sw_por", d[BIT_POR_FLAG], 1'b0);
      rd(OFS_MON_CTRL);
      chk("sw_men", d[BIT_MON_EN], 1'b0);
      rst_ok <= 1'b0;
      wait_halt(1'b1, 6);
      chk("sw_desel", halt, 1'b0);
      @(posedge clock);
      rst_ok <= 1'b1;
      wr(OFS_MON_CTRL, 32'h88);
      wr(OFS_RST_CAUSE, 32'h02);
      $display("t_sw done");
   endtask

   task t_pfail();
      slow <= 1'b1;
      @(posedge clock);
      rst_ok <= 1'b0;
      wait_halt(1'b1, 4);
      chk("pf_halt", halt, 1'b1);
      chk("pf_pin", pin_oe, 1'b1);
      repeat (6) @(negedge clock);
      chk("pf_hold", halt, 1'b1);
      @(posedge clock);
      rst_ok <= 1'b1;
      wait_halt(1'b0, 6);
      chk("pf_fast", n <= 3, 1'b1);
      chk("pf_ram", ram_ok, 1'b0);
      rd(OFS_RST_CAUSE);
      chk("pf_por", d[BIT_POR_FLAG], 1'b1);
      slow <= 1'b0;
      rd(OFS_MON_CTRL);
      chk("pf_men", d[BIT_MON_EN], 1'b1);
      $display("t_pfail done");
   endtask

   task t_sleep();
      sleep <= 1'b1;
      rst_ok <= 1'b0;
      wait_halt(1'b1, 8);
      chk("sl_halt", halt, 1'b0);
      chk("sl_ram", ram_ok, 1'b1);
      chk("sl_mon", mon_act, 1'b0);
      @(posedge clock);
      rst_ok <= 1'b1;
      @(posedge clock);
      sleep <= 1'b0;
      @(negedge clock);
      chk("wake_mon", mon_act, 1'b1);
      $display("t_sleep done");
   endtask

   task t_warn();
      @(posedge clock);
      warn_ok <= 1'b0;
      repeat (3) @(negedge clock);
      chk("w_irq", wirq, 1'b1);
      rd(OFS_MON_CTRL);
      chk("w_stat", d, 32'hC8);
      wr(OFS_MON_CTRL, 32'h80);
      @(negedge clock);
      chk("w_mask", wirq, 1'b0);
      rd(OFS_MON_CTRL);
      chk("w_ie", d, 32'hC0);
      warn_ok <= 1'b1;
      wr(OFS_MON_CTRL, 32'h88);
      $display("t_warn done");
   endtask

   task t_flash();
      wr(OFS_MON_CTRL, 32'h08);
      flash_req <= 1'b1;
      @(posedge clock);
      flash_req <= 1'b0;
      wait_halt(1'b1, 4);
      chk("fl_halt", halt, 1'b1);
      wait_halt(1'b0, 8);
      rd(OFS_RST_CAUSE);
      chk("fl_flag", d[BIT_FERR_FLAG], 1'b1);
      ext_rst <= 1'b1;
      wait_halt(1'b1, 4);
      chk("pin_oe", pin_oe, 1'b0);
      @(posedge clock);
      ext_rst <= 1'b0;
      wait_halt(1'b0, 8);
      rd(OFS_RST_CAUSE);
      chk("pin_por", d[BIT_POR_FLAG], 1'b0);
      wr(OFS_MON_CTRL, 32'h88);
      wr(OFS_RST_CAUSE, 32'h02);
      $display("t_flash done");
   endtask

   task t_por_monitor_disable();
      wr(OFS_PMU_MODE, 32'h20);
      @(negedge clock);
      chk("md_off", pmon_act, 1'b0);
      wr(OFS_RST_CAUSE, 32'h12);
      wait_halt(1'b1, 4);
      chk("md_pin", pin_oe, 1'b1);
      wait_halt(1'b0, 40);
      chk("md_delay", n >= PD - 1, 1'b1);
      chk("md_on", pmon_act, 1'b1);
      rd(OFS_RST_CAUSE);
      chk("md_por", d[BIT_POR_FLAG], 1'b1);
      $display("t_por_monitor_disable done");
   endtask

   task complete_run();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      nrst = 1'b0;
      apb_req = '0;
      por_ok = 1'b1;
      rst_ok = 1'b1;
      warn_ok = 1'b1;
      ext_rst = 1'b0;
      slow = 1'b0;
      sleep = 1'b0;
      flash_req = 1'b0;
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      t_por();
      t_sw();
      t_pfail();
      t_sleep();
      t_warn();
      t_flash();
      t_por_monitor_disable();
      complete_run();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clock);
      num_errors++;
      complete_run();
   end
endmodule
